// ---- sis_pkg.sv ----
// shared constants and carriers of the servo input sequencer
package sis_pkg;

    // =========================================================
    // register map and bus widths
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_FORCE    = 8'h04;
    localparam logic [7:0]  ADDR_ACCEL    = 8'h08;
    localparam logic [7:0]  ADDR_DECEL    = 8'h0c;
    localparam logic [7:0]  ADDR_JOG      = 8'h10;
    localparam logic [7:0]  ADDR_STATUS   = 8'h14;
    localparam logic [7:0]  ADDR_SPEED    = 8'h18;

    // =========================================================
    // control register fields and reset values
    localparam int          CTRL_UV_BIT   = 0;
    localparam int          CTRL_STOP_BIT = 1;
    localparam int          CTRL_RAMP_BIT = 2;
    localparam logic [2:0]  CTRL_RST      = 3'h1;
    localparam logic [19:0] FORCE_RST     = 20'h00000;
    localparam logic [15:0] ACCEL_RST     = 16'h0001;
    localparam logic [15:0] DECEL_RST     = 16'h0001;
    localparam logic [15:0] JOG_RST       = 16'h0064;

    // =========================================================
    // timing, in milliseconds at the given clock
    localparam int          CLK_KHZ       = 125000;
    localparam int          READY_MS      = 2000;
    localparam int          UV_WINDOW_MS  = 1000;
    localparam int          BLINK_MS      = 500;
    localparam int          RESPONSE_MS   = 1;

    // =========================================================
    // alarm code; value is arbitrary
    localparam logic [7:0]  ALARM_NONE    = 8'h00;
    localparam logic [7:0]  ALARM_MAIN_UV = 8'h0a;

    // =========================================================
    // sequence input functions, bit 19 first
    typedef struct packed {
        logic paramEditPermit;
        logic alarmReset;
        logic posPreset;
        logic interruptIn;
        logic homingLs;
        logic homing;
        logic posStart;
        logic rev;
        logic fwd;
        logic devClear;
        logic posCancel;
        logic pause;
        logic pulseInhibit;
        logic negativeOvertravelIn;
        logic positiveOvertravelIn;
        logic torqueLimit1;
        logic torqueLimit0;
        logic forcedStop;
        logic servoOn;
        logic freeRun;
    } sis_seq_in_s;

    typedef enum logic [1:0] {
        MS_COAST = 2'b00,
        MS_RUN   = 2'b01,
        MS_STOP  = 2'b10
    } sis_motion_e;

endpackage : sis_pkg

// ---- sis_servo_input_sequencer.sv ----
// servo input sequencer: input ranking, ready flags, mains loss, jog
// Notes on behaviour
// - inputs resolved in seven ranked classes
// - free-run, servo on top; forced stop second
// - torque limit selects form third class
// - overtravel, inhibit, pause, cancel, clear stop
// - motion commands yield to stops; overtravel blocks its own direction only
// - homing switch, interrupt, preset sixth class
// - alarm reset, edit permit lowest rank
// - terminals answered well within one millisecond
// - control ready about two seconds after power
// - control ready needs self-test pass, sticky
// - drive ready once servo on and rotatable
// - servo off while turning: decelerate, coast
// - settings can force input functions active
// - undervoltage if mains returns within window
// - no undervoltage if run released first
// - setting selects undervoltage alarm reporting
// - setting selects stop action on mains loss
// - mains loss drops drive ready, halts cpu if drive ready was set
// - alarm code shown blinking
// - run speed ramps only when ramp enable set; stop always ramps
// - keypad jog: up forward, down reverse
// - terminal fwd, rev ignored until jog returns to entry
module sis_servo_input_sequencer #(
    parameter int unsigned READY_CYCLES =
        sis_pkg::READY_MS * sis_pkg::CLK_KHZ,
    parameter int unsigned UV_CYCLES    =
        sis_pkg::UV_WINDOW_MS * sis_pkg::CLK_KHZ,
    parameter int unsigned BLINK_CYCLES =
        sis_pkg::BLINK_MS * sis_pkg::CLK_KHZ
) (
    input  wire logic                          clk,
    input  wire logic                          srst,
    input  wire logic [sis_pkg::ADDR_W-1:0]    addr,
    input  wire logic [sis_pkg::DATA_W-1:0]    wrData,
    input  wire logic                          wrStrobe,
    input  wire logic                          rdStrobe,
    output logic      [sis_pkg::DATA_W-1:0]    rdData,
    input  wire sis_pkg::sis_seq_in_s          terminals,
    input  wire logic                          selfTestOk,
    input  wire logic                          motorRotatable,
    input  wire logic                          mainsOn,
    input  wire logic                          dcLinkLow,
    input  wire logic                          keypadJogFunction,
    input  wire logic                          jogReturnToEntry,
    input  wire logic                          keyUp,
    input  wire logic                          keyDown,
    output logic                               ctrlReady,
    output logic                               driveReady,
    output logic                               torqueOn,
    output logic signed [15:0]                 speedCmd,
    output logic      [1:0]                    torqueLimitSel,
    output logic                               posStartPulse,
    output logic                               homingPulse,
    output logic                               homeEventPulse,
    output logic                               paramEditEnable,
    output logic      [2:0]                    activeClass,
    output logic                               cpuHalt,
    output logic                               alarmActive,
    output logic      [7:0]                    alarmCode,
    output logic                               displayLit
);

    // =========================================================
    // registers
    logic [2:0]                ctrl;
    logic [19:0]               forcedInputEnableSettings;
    logic [15:0]               accelTimeOne;
    logic [15:0]               decelTimeOne;
    logic [15:0]               jogSpeedSetting;
    logic                      undervoltageAlarmSelect;
    logic                      mainsLossStopAction;
    logic                      speedRampEnable;
    sis_pkg::sis_seq_in_s      eff;
    sis_pkg::sis_motion_e      state;
    sis_pkg::sis_motion_e      next_state;
    logic [31:0]               readyCnt;
    logic [31:0]               uvCnt;
    logic [31:0]               blinkCnt;
    logic                      uvArmed;
    logic                      dcLowSeen;
    logic                      jogLockout;
    logic                      posStartSeen;
    logic                      homingSeen;
    logic [2:0]                homeEventSeen;
    logic signed [15:0]        next_speed;
    logic signed [15:0]        target;
    logic                      stopActive;
    logic                      mainsLost;
    logic [2:0]                next_class;

    assign undervoltageAlarmSelect = ctrl[sis_pkg::CTRL_UV_BIT];
    assign mainsLossStopAction     = ctrl[sis_pkg::CTRL_STOP_BIT];
    assign speedRampEnable         = ctrl[sis_pkg::CTRL_RAMP_BIT];

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl                      <= sis_pkg::CTRL_RST;
            forcedInputEnableSettings <= sis_pkg::FORCE_RST;
            accelTimeOne              <= sis_pkg::ACCEL_RST;
            decelTimeOne              <= sis_pkg::DECEL_RST;
            jogSpeedSetting           <= sis_pkg::JOG_RST;
        end
        else if (wrStrobe)
        begin
            case (addr)
                sis_pkg::ADDR_CTRL:   ctrl <= wrData[2:0];
                sis_pkg::ADDR_FORCE:
                    forcedInputEnableSettings <= wrData[19:0];
                sis_pkg::ADDR_ACCEL:  accelTimeOne <= wrData[15:0];
                sis_pkg::ADDR_DECEL:  decelTimeOne <= wrData[15:0];
                sis_pkg::ADDR_JOG:    jogSpeedSetting <= wrData[15:0];
                default:              ;
            endcase
        end
    end

    // unmapped addresses and idle cycles read as zero
    always_ff @(posedge clk)
    begin
        if (srst)
            rdData <= '0;
        else if (rdStrobe)
        begin
            case (addr)
                sis_pkg::ADDR_CTRL:   rdData <= {29'h0, ctrl};
                sis_pkg::ADDR_FORCE:
                    rdData <= {12'h0, forcedInputEnableSettings};
                sis_pkg::ADDR_ACCEL:  rdData <= {16'h0, accelTimeOne};
                sis_pkg::ADDR_DECEL:  rdData <= {16'h0, decelTimeOne};
                sis_pkg::ADDR_JOG:    rdData <= {16'h0, jogSpeedSetting};
                sis_pkg::ADDR_STATUS:
                    rdData <= {8'h0, alarmCode, 5'h0, activeClass,
                               2'h0, state, torqueOn, cpuHalt,
                               driveReady, ctrlReady};
                sis_pkg::ADDR_SPEED:
                    rdData <= {{16{speedCmd[15]}}, speedCmd};
                default:              rdData <= '0;
            endcase
        end
        else
            rdData <= '0;
    end

    // =========================================================
    // forced inputs and ranking
    assign eff = sis_pkg::sis_seq_in_s'(terminals
                 | forcedInputEnableSettings);

    // every class is judged from the same sample
    always_comb
    begin
        next_class = 3'h0;
        if (eff.alarmReset || eff.paramEditPermit)
            next_class = 3'h7;
        if (eff.homingLs || eff.interruptIn || eff.posPreset)
            next_class = 3'h6;
        if (eff.fwd || eff.rev || eff.posStart || eff.homing)
            next_class = 3'h5;
        if (stopActive)
            next_class = 3'h4;
        if (eff.torqueLimit0 || eff.torqueLimit1)
            next_class = 3'h3;
        if (eff.forcedStop)
            next_class = 3'h2;
        if (eff.freeRun || eff.servoOn)
            next_class = 3'h1;
    end

    assign stopActive = eff.positiveOvertravelIn
                      | eff.negativeOvertravelIn | eff.pulseInhibit
                      | eff.pause | eff.posCancel | eff.devClear;
    assign mainsLost  = !mainsOn;

    // =========================================================
    // speed target: stops beat motion, jog beats terminals
    always_comb
    begin
        target = 16'sh0000;
        if (keypadJogFunction || jogLockout)
        begin
            if (keypadJogFunction && keyUp && !keyDown)
                target = $signed({1'b0, jogSpeedSetting[14:0]});
            else if (keypadJogFunction && keyDown && !keyUp)
                target = -$signed({1'b0, jogSpeedSetting[14:0]});
        end
        else if (eff.fwd && !eff.rev)
            target = $signed({1'b0, jogSpeedSetting[14:0]});
        else if (eff.rev && !eff.fwd)
            target = -$signed({1'b0, jogSpeedSetting[14:0]});
        if (eff.forcedStop || eff.pulseInhibit || eff.pause
            || eff.posCancel || eff.devClear)
            target = 16'sh0000;
        if (eff.positiveOvertravelIn && target > 16'sh0000)
            target = 16'sh0000;
        if (eff.negativeOvertravelIn && target < 16'sh0000)
            target = 16'sh0000;
    end

    // a zero step means a jump straight to the target
    function automatic logic signed [15:0] sis_ramp(
        input logic signed [15:0] cur,
        input logic signed [15:0] tgt,
        input logic        [15:0] up,
        input logic        [15:0] dn
    );
        logic signed [17:0] c;
        logic signed [17:0] t;
        logic signed [17:0] s;
        logic signed [17:0] n;
        logic               away;
        c    = 18'(cur);
        t    = 18'(tgt);
        away = (t > c && c >= 18'sh0) || (t < c && c <= 18'sh0);
        s    = away ? $signed({2'b00, up}) : $signed({2'b00, dn});
        if (s == 18'sh0)
            n = t;
        else if (t > c)
            n = (c + s > t) ? t : c + s;
        else
            n = (c - s < t) ? t : c - s;
        return 16'(n);
    endfunction : sis_ramp

    // =========================================================
    // motion state
    always_comb
    begin
        next_state = state;
        case (state)
            sis_pkg::MS_COAST:
                if (driveReady && eff.servoOn && !eff.freeRun)
                    next_state = sis_pkg::MS_RUN;
            sis_pkg::MS_RUN:
                if (eff.freeRun || alarmActive
                    || (mainsLost && !mainsLossStopAction))
                    next_state = sis_pkg::MS_COAST;
                else if (!eff.servoOn || mainsLost)
                    next_state = sis_pkg::MS_STOP;
            sis_pkg::MS_STOP:
                if (eff.freeRun || speedCmd == 16'sh0000)
                    next_state = sis_pkg::MS_COAST;
            default:
                next_state = sis_pkg::MS_COAST;
        endcase
    end

    always_comb
    begin
        next_speed = 16'sh0000;
        case (state)
            sis_pkg::MS_RUN:
                if (speedRampEnable)
                    next_speed = sis_ramp(speedCmd, target,
                                          accelTimeOne,
                                          decelTimeOne);
                else
                    next_speed = target;
            sis_pkg::MS_STOP:
                next_speed = sis_ramp(speedCmd, 16'sh0000,
                                      accelTimeOne, decelTimeOne);
            default:
                next_speed = 16'sh0000;
        endcase
        if (next_state == sis_pkg::MS_COAST)
            next_speed = 16'sh0000;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state    <= sis_pkg::MS_COAST;
            speedCmd <= 16'sh0000;
            torqueOn <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            speedCmd <= next_speed;
            torqueOn <= (next_state != sis_pkg::MS_COAST);
        end
    end

    // =========================================================
    // ready flags; only a power cycle drops control ready
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            readyCnt  <= 32'h0;
            ctrlReady <= 1'b0;
        end
        else
        begin
            if (readyCnt < 32'(READY_CYCLES))
                readyCnt <= readyCnt + 32'h1;
            else if (selfTestOk)
                ctrlReady <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            driveReady <= 1'b0;
            cpuHalt    <= 1'b0;
        end
        else
        begin
            if (mainsLost && driveReady)
                cpuHalt <= 1'b1;
            driveReady <= ctrlReady && eff.servoOn && motorRotatable
                          && mainsOn && !cpuHalt && !alarmActive
                          && !eff.freeRun;
        end
    end

    // =========================================================
    // main circuit undervoltage window
    // arming needs the run command at the moment the link drops
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            dcLowSeen <= 1'b0;
            uvArmed   <= 1'b0;
            uvCnt     <= 32'h0;
        end
        else
        begin
            dcLowSeen <= dcLinkLow;
            if (dcLinkLow && !dcLowSeen)
            begin
                uvArmed <= eff.servoOn;
                uvCnt   <= 32'h0;
            end
            else if (dcLinkLow && uvArmed)
            begin
                if (uvCnt >= 32'(UV_CYCLES) - 32'h1)
                    uvArmed <= 1'b0;
                else
                    uvCnt <= uvCnt + 32'h1;
            end
            else if (!dcLinkLow)
                uvArmed <= 1'b0;
        end
    end

    // a new alarm wins over a reset in the same cycle
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            alarmActive <= 1'b0;
            alarmCode   <= sis_pkg::ALARM_NONE;
        end
        else if (!dcLinkLow && dcLowSeen && uvArmed
                 && undervoltageAlarmSelect)
        begin
            alarmActive <= 1'b1;
            alarmCode   <= sis_pkg::ALARM_MAIN_UV;
        end
        else if (eff.alarmReset)
        begin
            alarmActive <= 1'b0;
            alarmCode   <= sis_pkg::ALARM_NONE;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst || !alarmActive)
        begin
            blinkCnt   <= 32'h0;
            displayLit <= 1'b1;
        end
        else if (blinkCnt >= 32'(BLINK_CYCLES) - 32'h1)
        begin
            blinkCnt   <= 32'h0;
            displayLit <= !displayLit;
        end
        else
            blinkCnt <= blinkCnt + 32'h1;
    end

    // =========================================================
    // keypad jog lockout of terminal rotation
    always_ff @(posedge clk)
    begin
        if (srst)
            jogLockout <= 1'b0;
        else if (keypadJogFunction)
            jogLockout <= 1'b1;
        else if (jogReturnToEntry)
            jogLockout <= 1'b0;
    end

    // =========================================================
    // ranked side outputs, all registered in one cycle
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            torqueLimitSel  <= 2'h0;
            posStartPulse   <= 1'b0;
            homingPulse     <= 1'b0;
            homeEventPulse  <= 1'b0;
            paramEditEnable <= 1'b0;
            activeClass     <= 3'h0;
            posStartSeen    <= 1'b0;
            homingSeen      <= 1'b0;
            homeEventSeen   <= 3'h0;
        end
        else
        begin
            activeClass     <= next_class;
            posStartSeen    <= eff.posStart;
            homingSeen      <= eff.homing;
            homeEventSeen   <= {eff.homingLs, eff.interruptIn,
                                eff.posPreset};
            torqueLimitSel  <= eff.forcedStop ? 2'h0
                : {eff.torqueLimit1, eff.torqueLimit0};
            posStartPulse   <= eff.posStart && !posStartSeen
                && !stopActive && !eff.forcedStop
                && state == sis_pkg::MS_RUN;
            homingPulse     <= eff.homing && !homingSeen
                && !stopActive && !eff.forcedStop
                && state == sis_pkg::MS_RUN;
            homeEventPulse  <= |({eff.homingLs, eff.interruptIn,
                eff.posPreset} & ~homeEventSeen);
            paramEditEnable <= eff.paramEditPermit;
        end
    end

endmodule : sis_servo_input_sequencer

// ---- sis_checker.sv ----
// port assertions and covers for the servo input sequencer
module sis_checker (
    input wire logic                 clk,
    input wire logic                 srst,
    input wire sis_pkg::sis_seq_in_s terminals,
    input wire logic                 mainsOn,
    input wire logic                 ctrlReady,
    input wire logic                 driveReady,
    input wire logic                 torqueOn,
    input wire logic [1:0]           torqueLimitSel,
    input wire logic                 posStartPulse,
    input wire logic                 homingPulse,
    input wire logic [2:0]           activeClass,
    input wire logic                 cpuHalt,
    input wire logic                 alarmActive,
    input wire logic                 displayLit
);
    timeunit 1ns;
    timeprecision 1ps;
    // =========================================================
    // output rules
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);

    a_ready_kept: assert property (ctrlReady |=> ctrlReady)
        else $error("control ready dropped");
    a_halt_kept: assert property (cpuHalt |=> cpuHalt)
        else $error("cpu halt dropped");
    a_mains_drop: assert property (!mainsOn [*3] |-> !driveReady)
        else $error("drive ready kept without mains");
    a_free_coast: assert property (
        terminals.freeRun [*3] |-> !torqueOn)
        else $error("motor powered during free-run");
    a_tl_forced: assert property (
        terminals.forcedStop |=> torqueLimitSel == 2'h0)
        else $error("torque limit select beat forced stop");
    a_start_block: assert property (
        posStartPulse |-> !$past(terminals.pause))
        else $error("start pulse passed a pause");
    a_homing_block: assert property (
        homingPulse |-> !$past(terminals.forcedStop))
        else $error("homing pulse passed a forced stop");
    a_top_class: assert property (
        terminals.freeRun |=> activeClass == 3'h1)
        else $error("free-run not ranked first");
    a_blink_idle: assert property (!alarmActive [*2] |-> displayLit)
        else $error("display dark without alarm");

    c_start: cover property (posStartPulse);
    c_blink: cover property (alarmActive && !displayLit);
    c_halt: cover property (cpuHalt && !driveReady);
endmodule : sis_checker

// ---- sis_host_plc.sv ----
// host controller model driving the sequence input terminals
module sis_host_plc (
    input  wire logic                 clk,
    input  wire sis_pkg::sis_seq_in_s want,
    output sis_pkg::sis_seq_in_s      terminals = '0
);
    timeunit 1ns;
    timeprecision 1ps;
    // =========================================================
    // scan register
    // levels change only once per scan, held for whole cycles
    always @(posedge clk)
        terminals <= want;
endmodule : sis_host_plc

// ---- test_servo_input_sequencer.sv ----
// self-checking bench of the servo input sequencer
module test_servo_input_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    // =========================================================
    // signals
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wrData = 32'h0;
    logic wrStrobe = 1'b0;
    logic rdStrobe = 1'b0;
    logic selfTestOk = 1'b1;
    logic motorRotatable = 1'b1;
    logic mainsOn = 1'b1;
    logic dcLinkLow = 1'b0;
    logic keypadJogFunction = 1'b0;
    logic jogReturnToEntry = 1'b0;
    logic keyUp = 1'b0;
    logic keyDown = 1'b0;
    sis_pkg::sis_seq_in_s want = '0;
    sis_pkg::sis_seq_in_s terminals;
    logic [31:0] rdData, r;
    logic signed [15:0] speedCmd;
    logic [7:0] alarmCode;
    logic [2:0] activeClass;
    logic ctrlReady, driveReady, torqueOn, paramEditEnable;
    logic cpuHalt, alarmActive, displayLit, sawDark, homeEventPulse;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int nHome = 0;
    int eHome = 0;

    sis_servo_input_sequencer #(.READY_CYCLES(20), .UV_CYCLES(10),
        .BLINK_CYCLES(4)) sis_servo_input_sequencer_i (.clk, .srst,
        .addr, .wrData, .wrStrobe, .rdStrobe, .rdData, .terminals,
        .selfTestOk, .motorRotatable, .mainsOn, .dcLinkLow,
        .keypadJogFunction, .jogReturnToEntry, .keyUp, .keyDown,
        .ctrlReady, .driveReady, .torqueOn, .speedCmd,
        .torqueLimitSel(), .posStartPulse(), .homingPulse(),
        .homeEventPulse, .paramEditEnable, .activeClass, .cpuHalt,
        .alarmActive, .alarmCode, .displayLit);
    sis_host_plc sis_host_plc_i (.clk, .want, .terminals);

    initial forever #4 clk = ~clk;

    always @(posedge clk)
        nHome += 32'(homeEventPulse);

    always @(posedge clk)
        if (++cyc == 6000)
        begin
            num_errors++;
            stop_test();
        end

    // =========================================================
    // helpers and reference model
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(logic [7:0] a, logic [31:0] d);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        tick(1);
        wrStrobe <= 1'b0;
        tick(1);
    endtask : wr

    // outputs are read before the edge's own updates land
    task automatic rd(logic [7:0] a, logic [31:0] e);
        addr <= a;
        rdStrobe <= 1'b1;
        tick(1);
        rdStrobe <= 1'b0;
        tick(1);
        chk("rdData", e, rdData);
    endtask : rd

    task automatic uvCase(int hold, logic [31:0] e);
        dcLinkLow <= 1'b1;
        tick(hold);
        dcLinkLow <= 1'b0;
        tick(3);
        chk("alarmActive", e, 32'(alarmActive));
    endtask : uvCase

    // bit order of the carrier follows rank, so the lowest set bit wins
    function automatic int cls(logic [19:0] v);
        int t[20] = '{1,1,2,3,3,4,4,4,4,4,4,5,5,5,5,6,6,6,7,7};
        for (int i = 0; i < 20; i++)
            if (v[i])
                return t[i];
        return 0;
    endfunction : cls

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    // =========================================================
    // tests
    initial
    begin
        r = $urandom(32'he8c4b5c9);
        tick(6);
        srst <= 1'b0;
        tick(18);
        chk("ctrlReady", 32'h0, 32'(ctrlReady));
        tick(5);
        chk("ctrlReady", 32'h1, 32'(ctrlReady));
        rd(sis_pkg::ADDR_CTRL, 32'(sis_pkg::CTRL_RST));
        rd(sis_pkg::ADDR_FORCE, 32'h0);
        rd(sis_pkg::ADDR_JOG, 32'(sis_pkg::JOG_RST));
        rd(8'h1c, 32'h0);
        rd(sis_pkg::ADDR_STATUS, 32'h1);
        r = $urandom;
        wr(sis_pkg::ADDR_ACCEL, r);
        rd(sis_pkg::ADDR_ACCEL, {16'h0, r[15:0]});
        $display("test power-up done");
        for (int k = 0; k < 40; k++)
        begin
            r = (k < 20) ? 32'h1 << k : $urandom;
            eHome += int'(|(r[17:15] & ~want[17:15]));
            want <= r[19:0];
            tick(4);
            chk("activeClass", cls(r[19:0]), 32'(activeClass));
        end
        want <= '0;
        wr(sis_pkg::ADDR_FORCE, 32'h80000);
        tick(3);
        chk("paramEditEnable", 32'h1, 32'(paramEditEnable));
        chk("activeClass", 32'h7, 32'(activeClass));
        want <= 20'h00001;
        wr(sis_pkg::ADDR_FORCE, 32'h0);
        chk("homeEventPulse", eHome, nHome);
        $display("test ranking done");
        want <= 20'h0802;
        tick(10);
        chk("driveReady", 32'h1, 32'(driveReady));
        chk("speedCmd", 32'h64, 32'(speedCmd));
        want <= 20'h2902;
        tick(4);
        chk("speedCmd", 32'h0, 32'(speedCmd));
        want <= 20'h0002;
        tick(3);
        want <= 20'h2002;
        keypadJogFunction <= 1'b1;
        keyDown <= 1'b1;
        tick(6);
        chk("speedCmd", 32'hffffff9c, 32'(speedCmd));
        keyDown <= 1'b0;
        keypadJogFunction <= 1'b0;
        want <= 20'h2802;
        tick(6);
        chk("speedCmd", 32'h0, 32'(speedCmd));
        jogReturnToEntry <= 1'b1;
        tick(2);
        jogReturnToEntry <= 1'b0;
        tick(6);
        chk("speedCmd", 32'h64, 32'(speedCmd));
        want <= 20'h0002;
        $display("test motion done");
        uvCase(3, 32'h1);
        chk("alarmCode", 32'h0a, 32'(alarmCode));
        sawDark = 1'b0;
        repeat (10)
        begin
            tick(1);
            sawDark = sawDark | !displayLit;
        end
        chk("blink", 32'h1, 32'(sawDark));
        want <= 20'h40002;
        tick(4);
        want <= 20'h00002;
        tick(2);
        chk("alarmActive", 32'h0, 32'(alarmActive));
        uvCase(14, 32'h0);
        wr(sis_pkg::ADDR_CTRL, 32'h0);
        uvCase(3, 32'h0);
        wr(sis_pkg::ADDR_CTRL, 32'h1);
        want <= '0;
        tick(8);
        uvCase(3, 32'h0);
        $display("test undervoltage done");
        wr(sis_pkg::ADDR_CTRL, 32'h3);
        want <= 20'h802;
        tick(8);
        chk("driveReady", 32'h1, 32'(driveReady));
        mainsOn <= 1'b0;
        tick(4);
        chk("driveReady", 32'h0, 32'(driveReady));
        chk("cpuHalt", 32'h1, 32'(cpuHalt));
        chk("speedCmd", 32'h62, 32'(speedCmd));
        srst <= 1'b1;
        mainsOn <= 1'b1;
        tick(2);
        srst <= 1'b0;
        tick(30);
        chk("driveReady", 32'h1, 32'(driveReady));
        mainsOn <= 1'b0;
        tick(4);
        chk("torqueOn", 32'h0, 32'(torqueOn));
        $display("test mains loss done");
        stop_test();
    end
endmodule : test_servo_input_sequencer

bind sis_servo_input_sequencer sis_checker sis_checker_i (.clk, .srst,
    .terminals, .mainsOn, .ctrlReady, .driveReady, .torqueOn,
    .torqueLimitSel, .posStartPulse, .homingPulse, .activeClass, .cpuHalt,
    .alarmActive, .displayLit);
